// ===== ptmr_core_model.sv
// completion acceptor standing in for the core's transmit side
// assumes clk_sys and rst of the responder
`timescale 1ns/1ps
`default_nettype none
module ptmr_core_model
   import ptmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cpl_valid,
   input wire logic [1:0] mode,
   output logic cpl_ready
);
   // ====================
   // acceptance pacing
   logic [2:0] cnt_q = 3'h0;
   // mode 0 prompt, 1 one edge in eight, 2 stalled; changes just after the edge
   always @(posedge clk_sys) begin
      cnt_q <= #1 cnt_q + 3'h1;
      cpl_ready <= #1 !rst && (mode == 2'd0 || (mode == 2'd1 && cnt_q == 3'h5));
   end
endmodule
`default_nettype wire

// ===== ptmr_pkg.sv
// types shared by the target memory responder
// assumes ptmr_regs.svh holds the numeric constants
package ptmr_pkg;
   // region selected for a request
   typedef enum logic [1:0] {
      PTMR_RGN_IO = 2'h0,
      PTMR_RGN_MEM32 = 2'h1,
      PTMR_RGN_MEM64 = 2'h2,
      PTMR_RGN_EXPROM = 2'h3
   } ptmr_region_t;
   // receive engine states, gray along idle-read-complete
   typedef enum logic [1:0] {
      PTMR_ST_IDLE = 2'b00,
      PTMR_ST_READ = 2'b01,
      PTMR_ST_CPL = 2'b11,
      PTMR_ST_WRITE = 2'b10
   } ptmr_state_t;
   // request fields kept while the access is serviced
   typedef struct packed {
      ptmr_region_t region;
      logic [8:0] dw_addr;
      logic [3:0] be;
      logic [31:0] data;
      logic [15:0] rid;
      logic [7:0] tag;
      logic [2:0] tc;
      logic [1:0] attr;
      logic is_io;
      logic [6:0] low_addr;
   } ptmr_req_t;
   // completion request handed to the transmit side
   typedef struct packed {
      logic with_data;
      logic [2:0] status;
      logic [15:0] rid;
      logic [7:0] tag;
      logic [2:0] tc;
      logic [1:0] attr;
      logic [6:0] low_addr;
      logic [31:0] data;
   } ptmr_cpl_t;
endpackage

// ===== ptmr_regs.svh
// field positions, codes and sizes of the target memory responder
// assumes the includer sees plain text macros only
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH
`define PTMR_BAR_MSB 9
`define PTMR_BAR_LSB 2
`define PTMR_FMT_MSB 30
`define PTMR_FMT_LSB 29
`define PTMR_TYPE_MSB 28
`define PTMR_TYPE_LSB 24
`define PTMR_TC_MSB 22
`define PTMR_TC_LSB 20
`define PTMR_ATTR_MSB 13
`define PTMR_ATTR_LSB 12
`define PTMR_LEN_MSB 9
`define PTMR_LEN_LSB 0
`define PTMR_RID_MSB 31
`define PTMR_RID_LSB 16
`define PTMR_TAG_MSB 15
`define PTMR_TAG_LSB 8
`define PTMR_FBE_MSB 3
`define PTMR_FBE_LSB 0
`define PTMR_ADDR_MSB 10
`define PTMR_ADDR_LSB 2
`define PTMR_LOWADDR_MSB 6
`define PTMR_FMT_3DW_NODATA 2'b00
`define PTMR_FMT_4DW_NODATA 2'b01
`define PTMR_FMT_3DW_DATA 2'b10
`define PTMR_FMT_4DW_DATA 2'b11
`define PTMR_TYPE_MEM 5'h00
`define PTMR_TYPE_IO 5'h02
`define PTMR_LEN_ONE 10'h001
`define PTMR_CPL_SC 3'h0
`define PTMR_CAP_DW 5
`define PTMR_CAP_MAX 3'h5
`define PTMR_HDR3_DATA_DW 3
`define PTMR_HDR4_DATA_DW 4
`define PTMR_HDR3_ADDR_DW 2
`define PTMR_HDR4_ADDR_DW 3
`define PTMR_RAM_WORDS 512
`define PTMR_REGIONS 4
`endif

// ===== ptmr_responder.sv
// target-only memory responder: decodes single-dword requests from the
// receive stream, serves four block ram regions and requests completions
// assumes the endpoint core delivers only bar-matched requests in order
//
// Operation
// - four separate 2 KB regions, 8192 bytes in total.
// - single-dword reads and writes to mem32, mem64 and io spaces.
// - target bar taken from sideband user bits 9:2.
// - datapath width parameter covers 32, 64 and 128 bit streams.
// - every valid read returns a completion with one dword of data.
// - io write returns a successful completion without data.
// - one-dword write payload stored at addressed region location.
// - memory write ends at storage update, no completion produced.
// - all four 2 KB regions share one array with one write and one read port.
// - io, mem32 bar0, mem64 and expansion rom bar map to regions.
// - only one bar of each type served; others get no completion.
// - addresses beyond 2 KB wrap onto the same region.
// - requests longer than one dword are drained and dropped.
// - payload, address and region fixed before the write enable.
// - accept-ready held low while a ram write is in progress.
// - accept-ready held low until read done and completion made.
// - next request waits for completion sent or write pending low.
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_regs.svh"
module ptmr_responder
   import ptmr_pkg::*;
#(
   parameter int DATA_W = 64,
   parameter logic [7:0] IO_BAR_MASK = 8'h00,
   parameter logic [7:0] MEM32_BAR_MASK = 8'h01,
   parameter logic [7:0] MEM64_BAR_MASK = 8'h00,
   parameter logic [7:0] EXPROM_BAR_MASK = 8'h40
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [DATA_W-1:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_last,
   input wire logic [21:0] rx_user,
   output logic rx_accept_ready,
   output logic cpl_valid,
   output ptmr_cpl_t cpl,
   input wire logic cpl_ready,
   output logic ram_write_pending
);
   localparam int DW_BEAT = DATA_W / 32;

   // ==========================================================
   // receive capture and decode
   // ==========================================================
   ptmr_state_t state_q, state_d;
   logic [`PTMR_CAP_DW-1:0][31:0] cap_q, cap_d;
   logic [2:0] cnt_q, cnt_d;
   ptmr_req_t req_q, req_d;
   ptmr_cpl_t cpl_q, cpl_d;
   logic rx_fire, pkt_end, completion_sent, hdr4, has_data, len_ok, region_ok;
   logic [1:0] fmt;
   logic [4:0] ttype;
   logic [7:0] bar_hit;
   ptmr_region_t region;
   logic [31:0] rd_word;
   // region ram, one array indexed by region
   logic [31:0] region_ram [`PTMR_REGIONS][`PTMR_RAM_WORDS];

   assign rx_fire = rx_valid && rx_accept_ready;
   assign pkt_end = rx_fire && rx_last;
   assign completion_sent = cpl_valid && cpl_ready;
   assign rx_accept_ready = (state_q == PTMR_ST_IDLE);
   assign ram_write_pending = (state_q == PTMR_ST_WRITE);
   assign cpl_valid = (state_q == PTMR_ST_CPL);
   assign cpl = cpl_q;

   // dword capture; any beat width packs into the same buffer
   // width independent capture
   always_comb begin
      logic [3:0] idx;
      idx = 4'h0;
      cap_d = cap_q;
      cnt_d = cnt_q;
      if (rx_fire) begin
         for (int i = 0; i < DW_BEAT; i++) begin
            idx = 4'(cnt_q) + 4'(i);
            if (idx < 4'(`PTMR_CAP_MAX)) begin
               cap_d[idx[2:0]] = rx_data[i*32 +: 32];
            end
         end
         if (rx_last) begin
            cnt_d = 3'h0;
         end else if (4'(cnt_q) + 4'(DW_BEAT) < 4'(`PTMR_CAP_MAX)) begin
            cnt_d = 3'(4'(cnt_q) + 4'(DW_BEAT));
         end else begin
            cnt_d = `PTMR_CAP_MAX;
         end
      end
   end

   assign fmt = cap_d[0][`PTMR_FMT_MSB:`PTMR_FMT_LSB];
   assign ttype = cap_d[0][`PTMR_TYPE_MSB:`PTMR_TYPE_LSB];
   assign hdr4 = fmt[0];
   assign has_data = fmt[1];
   assign bar_hit = rx_user[`PTMR_BAR_MSB:`PTMR_BAR_LSB];
   assign len_ok = (cap_d[0][`PTMR_LEN_MSB:`PTMR_LEN_LSB] == `PTMR_LEN_ONE);

   // region choice by type and the one bar served per type
   // region map
   always_comb begin
      region = PTMR_RGN_IO;
      region_ok = 1'b0;
      if (ttype == `PTMR_TYPE_IO && !hdr4) begin
         region = PTMR_RGN_IO;
         region_ok = |(bar_hit & IO_BAR_MASK);
      end else if (ttype == `PTMR_TYPE_MEM && !hdr4) begin
         if (|(bar_hit & EXPROM_BAR_MASK)) begin
            region = PTMR_RGN_EXPROM;
            region_ok = 1'b1;
         end else begin
            region = PTMR_RGN_MEM32;
            region_ok = |(bar_hit & MEM32_BAR_MASK);
         end
      end else if (ttype == `PTMR_TYPE_MEM && hdr4) begin
         region = PTMR_RGN_MEM64;
         region_ok = |(bar_hit & MEM64_BAR_MASK);
      end
   end

   // request capture and sequencing
   always_comb begin
      logic [31:0] addr_dw;
      addr_dw = hdr4 ? cap_d[`PTMR_HDR4_ADDR_DW] : cap_d[`PTMR_HDR3_ADDR_DW];
      state_d = state_q;
      req_d = req_q;
      cpl_d = cpl_q;
      case (state_q)
         PTMR_ST_IDLE: begin
            if (pkt_end && len_ok && region_ok) begin
               req_d.region = region;
               req_d.dw_addr = addr_dw[`PTMR_ADDR_MSB:`PTMR_ADDR_LSB];
               req_d.low_addr = addr_dw[`PTMR_LOWADDR_MSB:0];
               req_d.be = cap_d[1][`PTMR_FBE_MSB:`PTMR_FBE_LSB];
               req_d.data = hdr4 ? cap_d[`PTMR_HDR4_DATA_DW] : cap_d[`PTMR_HDR3_DATA_DW];
               req_d.rid = cap_d[1][`PTMR_RID_MSB:`PTMR_RID_LSB];
               req_d.tag = cap_d[1][`PTMR_TAG_MSB:`PTMR_TAG_LSB];
               req_d.tc = cap_d[0][`PTMR_TC_MSB:`PTMR_TC_LSB];
               req_d.attr = cap_d[0][`PTMR_ATTR_MSB:`PTMR_ATTR_LSB];
               req_d.is_io = (ttype == `PTMR_TYPE_IO);
               state_d = has_data ? PTMR_ST_WRITE : PTMR_ST_READ;
            end
         end
         PTMR_ST_WRITE: begin
            // io write answered; memory write silent
            cpl_d = '{with_data: 1'b0, status: `PTMR_CPL_SC, rid: req_q.rid, tag: req_q.tag,
                      tc: req_q.tc, attr: req_q.attr, low_addr: req_q.low_addr, data: 32'h0000_0000};
            state_d = req_q.is_io ? PTMR_ST_CPL : PTMR_ST_IDLE;
         end
         PTMR_ST_READ: begin
            cpl_d = '{with_data: 1'b1, status: `PTMR_CPL_SC, rid: req_q.rid, tag: req_q.tag,
                      tc: req_q.tc, attr: req_q.attr, low_addr: req_q.low_addr, data: rd_word};
            state_d = PTMR_ST_CPL;
         end
         PTMR_ST_CPL: begin
            if (completion_sent) begin
               state_d = PTMR_ST_IDLE;
            end
         end
         default: state_d = PTMR_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= PTMR_ST_IDLE;
         cnt_q <= 3'h0;
         cap_q <= '0;
         req_q <= '0;
         cpl_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cap_q <= cap_d;
         req_q <= req_d;
         cpl_q <= cpl_d;
      end
   end

   // ==========================================================
   // region rams: write port and synchronous-style read port
   // ==========================================================
   // read is combinational into cpl_q so the data leaves from a flop
   assign rd_word = region_ram[req_q.region][req_q.dw_addr];

   always_ff @(posedge clk_sys) begin
      if (state_q == PTMR_ST_WRITE) begin
         for (int b = 0; b < 4; b++) begin
            if (req_q.be[b]) begin
               region_ram[req_q.region][req_q.dw_addr][b*8 +: 8] <= req_q.data[b*8 +: 8];
            end
         end
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   sequence s_read_start;
      state_q == PTMR_ST_READ;
   endsequence
   sequence s_cpl_data;
      cpl_valid && cpl.with_data && !rx_accept_ready;
   endsequence

   a_write_stalls_rx: assert property (@(posedge clk_sys) disable iff (rst)
      ram_write_pending |-> !rx_accept_ready) else $error("ready high during ram write");
   a_read_gives_data: assert property (@(posedge clk_sys) disable iff (rst)
      s_read_start |=> s_cpl_data) else $error("read did not give data completion");
   a_read_holds_ready: assert property (@(posedge clk_sys) disable iff (rst)
      s_read_start |-> !rx_accept_ready ##1 (!rx_accept_ready throughout (cpl_valid [*1]))) else $error("ready rose early");
   a_cpl_sent_frees: assert property (@(posedge clk_sys) disable iff (rst)
      completion_sent |=> rx_accept_ready && !cpl_valid) else $error("not idle after completion");
   a_iowr_no_data: assert property (@(posedge clk_sys) disable iff (rst)
      (ram_write_pending && req_q.is_io) |=> cpl_valid && !cpl.with_data && cpl.status == `PTMR_CPL_SC)
      else $error("io write completion wrong");
   a_memwr_silent: assert property (@(posedge clk_sys) disable iff (rst)
      (ram_write_pending && !req_q.is_io) |=> !cpl_valid && rx_accept_ready) else $error("memory write answered");
   a_long_dropped: assert property (@(posedge clk_sys) disable iff (rst)
      (pkt_end && !len_ok && state_q == PTMR_ST_IDLE) |=> rx_accept_ready) else $error("long request not dropped");
   a_write_stored: assert property (@(posedge clk_sys) disable iff (rst)
      (ram_write_pending && req_q.be == 4'hf) |=> region_ram[$past(req_q.region)][$past(req_q.dw_addr)] == $past(req_q.data))
      else $error("write payload not stored");
   a_tag_copied: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(cpl_valid) |-> cpl.tag == req_q.tag && cpl.rid == req_q.rid && cpl.tc == req_q.tc) else $error("identity not copied");
   a_reset_idle: assert property (@(posedge clk_sys)
      rst |=> rx_accept_ready && !cpl_valid) else $error("reset not idle");
   a_unmapped_bar: assert property (@(posedge clk_sys) disable iff (rst)
      (pkt_end && !region_ok && state_q == PTMR_ST_IDLE) |=> rx_accept_ready ##1 !cpl_valid) else $error("unmapped bar served");
endmodule
`default_nettype wire

// ===== ptmr_responder_test.sv
// self-checking bench for the target memory responder, 64-bit stream
// assumes io on bar2 and mem64 on bar4 are enabled by parameter
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_regs.svh"
module ptmr_responder_test
   import ptmr_pkg::*;
;
   logic clk_sys = 0, rst = 1, rx_valid = 0, rx_last = 0, cpl_ready, cpl_valid;
   logic rx_accept_ready, ram_write_pending;
   logic [1:0] mode = 2'd0;
   logic [63:0] rx_data = 64'h0;
   logic [21:0] rx_user = 22'h0;
   logic [7:0] bars [0:3] = '{8'h04, 8'h01, 8'h10, 8'h40};
   logic [31:0] mem [0:3][0:511];
   ptmr_cpl_t cpl;
   ptmr_cpl_t exp_q[$];
   int fail_count = 0, checks_done = 0, seed = 57;
   // ====================
   // design and partner
   ptmr_responder #(.DATA_W(64), .IO_BAR_MASK(8'h04), .MEM64_BAR_MASK(8'h10)) dut (.clk_sys(clk_sys), .rst(rst),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_user(rx_user),
      .rx_accept_ready(rx_accept_ready), .cpl_valid(cpl_valid), .cpl(cpl), .cpl_ready(cpl_ready),
      .ram_write_pending(ram_write_pending));
   ptmr_core_model core (.clk_sys(clk_sys), .rst(rst), .cpl_valid(cpl_valid), .mode(mode), .cpl_ready(cpl_ready));
   initial forever #50 clk_sys = ~clk_sys;
   // ====================
   // checking helpers
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      // an unknown never counts as a match, even against an unknown model word
      if (got !== exp || $isunknown(got)) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // completions are matched oldest first at the accepting edge
   always @(posedge clk_sys) begin
      ptmr_cpl_t e;
      if (rst === 1'b0 && cpl_valid === 1'b1 && cpl_ready === 1'b1) begin
         if (exp_q.size() == 0) chk("spare completion", 64'h0, 64'h1);
         else begin
            e = exp_q.pop_front();
            chk("cpl fields", {e.with_data, e.status, e.rid, e.tag, e.tc, e.attr, e.low_addr},
               {cpl.with_data, cpl.status, cpl.rid, cpl.tag, cpl.tc, cpl.attr, cpl.low_addr});
            if (e.with_data) chk("cpl data", e.data, cpl.data);
         end
      end
   end
   // ====================
   // one request: header, address, payload, two dwords a beat
   task automatic send(input logic [1:0] fmt, input logic [4:0] typ, input logic [7:0] bar,
         input logic [31:0] addr, input logic [31:0] wd, input logic [9:0] len);
      logic [31:0] dw[$];
      ptmr_cpl_t e;
      int rg;
      int n;
      logic good;
      logic acc;
      rg = bar == 8'h04 ? 0 : bar == 8'h01 ? 1 : bar == 8'h10 ? 2 : bar == 8'h40 ? 3 : -1;
      good = rg >= 0 && len == 10'h001;
      e = '0;
      e.rid = 16'($random(seed));
      e.tag = 8'($random(seed));
      e.tc = 3'($random(seed));
      e.attr = 2'($random(seed));
      e.low_addr = addr[6:0];
      e.with_data = !fmt[1];
      dw.push_back({1'b0, fmt, typ, 1'b0, e.tc, 6'h00, e.attr, 2'b00, len});
      dw.push_back({e.rid, e.tag, 4'h0, 4'hF});
      if (fmt[0]) dw.push_back(32'h0000_0000);
      dw.push_back(addr);
      for (int i = 0; i < len && fmt[1]; i++) dw.push_back(wd + i);
      if (dw.size() % 2) dw.push_back(~dw[$]);
      // one idle edge between packets, so valid is never set twice in a step
      @(posedge clk_sys);
      #1;
      // bar bits ride with every beat
      for (int i = 0; i < dw.size(); i += 2) begin
         rx_data = {dw[i+1], dw[i]};
         rx_valid = 1'b1;
         rx_last = i + 2 >= dw.size();
         rx_user = {12'($random(seed)), bar, 2'($random(seed))};
         n = 0;
         // ready only moves at an edge, so its value now is what the next edge takes
         do begin
            acc = (rx_accept_ready === 1'b1);
            @(posedge clk_sys);
            #1;
            n++;
         end while (!acc && n < 60);
         if (!acc) chk("accept wait", 64'h0, 64'h1);
      end
      rx_valid = 1'b0;
      rx_last = 1'b0;
      rx_data = ~rx_data;
      chk("stall", {63'h0, !good}, {63'h0, rx_accept_ready});
      if (good && fmt[1]) chk("ram write", 64'h1, {63'h0, ram_write_pending});
      if (good && fmt[1]) mem[rg][addr[10:2]] = wd;
      if (good && !fmt[1]) e.data = mem[rg][addr[10:2]];
      if (good && (!fmt[1] || typ == `PTMR_TYPE_IO)) exp_q.push_back(e);
   endtask
   task automatic wr(input int r, input logic [31:0] a, input logic [31:0] d, input logic [9:0] len);
      send(r == 2 ? `PTMR_FMT_4DW_DATA : `PTMR_FMT_3DW_DATA, r == 0 ? `PTMR_TYPE_IO : `PTMR_TYPE_MEM, bars[r], a, d, len);
   endtask
   task automatic rd(input int r, input logic [31:0] a);
      send(r == 2 ? `PTMR_FMT_4DW_NODATA : `PTMR_FMT_3DW_NODATA, r == 0 ? `PTMR_TYPE_IO : `PTMR_TYPE_MEM, bars[r], a, 0, 1);
   endtask
   // ====================
   // main sequence
   initial begin
      logic [31:0] a;
      repeat (12) @(posedge clk_sys);
      #1 rst = 1'b0;
      for (int r = 0; r < 4; r++) wr(r, 32'h0000_0124, 32'hA5A5_0000 + r, 1);
      for (int r = 0; r < 4; r++) rd(r, 32'h0000_0124);
      $display("regions done");
      wr(1, 32'h0000_0924, 32'h1234_5678, 1);
      rd(1, 32'h0000_0124);
      wr(1, 32'h0000_0124, 32'hDEAD_0000, 2);
      rd(1, 32'h0000_0124);
      send(`PTMR_FMT_3DW_NODATA, `PTMR_TYPE_MEM, 8'h02, 32'h0000_0124, 0, 1);
      send(`PTMR_FMT_3DW_DATA, `PTMR_TYPE_MEM, 8'h08, 32'h0000_0124, 1, 1);
      $display("wrap drop unserved done");
      mode = 2'd1;
      for (int k = 0; k < 24; k++) begin
         // read back the written word through its other 2 KB alias
         a = $random(seed) & 32'h0000_0FFC;
         wr(1 + k % 2, a, $random(seed), 1);
         rd(1 + k % 2, a ^ 32'h0000_0800);
      end
      // let the last paced completion go before the core stalls in mode 2
      repeat (20) @(posedge clk_sys);
      #1;
      chk("drained", 64'h0, 64'(exp_q.size()));
      $display("random traffic done");
      mode = 2'd2;
      rd(1, 32'h0000_0124);
      repeat (5) @(posedge clk_sys);
      #1;
      chk("held cpl", 64'h1, {63'h0, cpl_valid});
      rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      exp_q.delete();
      chk("reset state", 64'h1, {62'h0, cpl_valid, rx_accept_ready});
      mode = 2'd0;
      rd(1, 32'h0000_0124);
      repeat (20) @(posedge clk_sys);
      chk("unanswered", 64'h0, 64'(exp_q.size()));
      $display("reset done");
      print_verdict();
   end
   // watchdog, far above the several hundred cycles used
   initial begin
      #3_000_000;
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
